//--- core/chg_pkg.sv
// Constants, field layouts and encodings of the charge cycle sequencer.
// Assumes a 100 MHz core clock and a classic Wishbone register bus.
package chg_pkg;

  // ----------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADR_CTRL   = 8'h00;
  localparam logic [7:0] ADR_PARAM  = 8'h04;
  localparam logic [7:0] ADR_STATUS = 8'h08;

  // ----------------------------------------------------------------------
  // Control register bits
  // ----------------------------------------------------------------------
  localparam int CTL_DIS     = 0;
  localparam int CTL_TERM_EN = 1;
  localparam int CTL_STAT_EN = 2;
  localparam int CTL_PRST    = 3;
  localparam int CTL_KICK    = 4;
  localparam int CTL_HZ      = 5;
  localparam int CTL_IIN500  = 6;
  localparam int CTL_IIN_OFF = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // ----------------------------------------------------------------------
  // Charge parameter register fields
  // ----------------------------------------------------------------------
  localparam int FAST_LSB = 0;
  localparam int TERM_LSB = 4;
  localparam int VREG_LSB = 8;
  localparam int REG_BASE_MV    = 3500;
  localparam int REG_STEP_MV    = 20;
  localparam int REG_DEFAULT_MV = 3540;
  localparam logic [3:0] FAST_RESET = 4'h0;
  localparam logic [3:0] TERM_RESET = 4'h1;
  localparam logic [5:0] VREG_RESET =
    6'((REG_DEFAULT_MV - REG_BASE_MV) / REG_STEP_MV);
  localparam logic [13:0] PARAM_RESET = {VREG_RESET, TERM_RESET, FAST_RESET};

  // ----------------------------------------------------------------------
  // Status register fields and fault codes
  // ----------------------------------------------------------------------
  localparam int FLT_LSB   = 0;
  localparam int PHASE_LSB = 4;
  localparam int SMODE_BIT = 7;
  localparam logic [2:0] FLT_NONE  = 3'h0;
  localparam logic [2:0] FLT_INOV  = 3'h1;
  localparam logic [2:0] FLT_BATOV = 3'h2;
  localparam logic [2:0] FLT_THERM = 3'h3;
  localparam logic [2:0] FLT_TIMER = 3'h4;
  localparam logic [2:0] FLT_POOR  = 3'h5;
  localparam logic [2:0] FLT_NOBAT = 3'h6;

  // ----------------------------------------------------------------------
  // Synchronised pin indices
  // ----------------------------------------------------------------------
  localparam int PIN_SHORT = 0;
  localparam int PIN_WEAK  = 1;
  localparam int PIN_RECH  = 2;
  localparam int PIN_TERM  = 3;
  localparam int PIN_THERM = 4;
  localparam int PIN_POOR  = 5;
  localparam int PIN_INOV  = 6;
  localparam int PIN_BATOV = 7;
  localparam int PIN_OTG   = 8;
  localparam int PIN_AUTO  = 9;
  localparam int NPINS     = 10;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ       = 100_000_000;
  localparam int CYC_PER_US   = CLK_HZ / 1_000_000;
  localparam int CYC_PER_MS_D = CLK_HZ / 1_000;
  localparam int TMR_W        = 21;
  localparam int DLY_W        = 16;
  localparam int LONG_MIN     = 32;
  localparam int SHORT_S      = 32;
  localparam int LONG_MS_D    = LONG_MIN * 60 * 1000;
  localparam int SHORT_MS_D   = SHORT_S * 1000;
  localparam int RETRY_MS     = 1000;
  localparam int DETECT_MS    = 250;
  localparam int STAT_PULSE_US = 128;

endpackage : chg_pkg

//--- core/chg_if.sv
// Interfaces between the sequencer and its tick and pin helpers.
// Assumes the package chg_pkg is compiled first.
`timescale 1ns/1ps
`default_nettype none
interface tick_if;
  logic tick_us;
  logic tick_ms;
  modport src (output tick_us, output tick_ms);
  modport dst (input tick_us, input tick_ms);
endinterface : tick_if

interface pin_if;
  import chg_pkg::*;
  logic [NPINS-1:0] level;
  modport src (output level);
  modport dst (input level);
endinterface : pin_if
`default_nettype wire

//--- core/pin_sync.sv
// Two-flop synchroniser for every analog comparator and strap input.
// Assumes raw inputs are asynchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
module pin_sync import chg_pkg::*; (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Raw levels
  input  wire logic [NPINS-1:0] raw_i,
  // Synchronised levels
  pin_if.src                    pins
);
  typedef struct packed {
    logic [NPINS-1:0] meta;
    logic [NPINS-1:0] sync;
  } sync_state_t;

  sync_state_t s_q;
  sync_state_t s_d;

  always_comb begin
    s_d      = s_q;
    s_d.meta = raw_i;
    s_d.sync = s_q.meta;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pins.level = s_q.sync;
endmodule : pin_sync
`default_nettype wire

//--- core/tick_gen.sv
// Microsecond and millisecond enable pulses derived from clk_i.
// Assumes CYC_PER_MS fits in 17 bits.
`timescale 1ns/1ps
`default_nettype none
module tick_gen import chg_pkg::*; #(
  parameter int unsigned CYC_PER_MS = CYC_PER_MS_D
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Ticks
  tick_if.src       ticks
);
  localparam logic [6:0]  US_LAST = 7'(CYC_PER_US - 1);
  localparam logic [16:0] MS_LAST = 17'(CYC_PER_MS - 1);

  typedef struct packed {
    logic [6:0]  us_cnt;
    logic [16:0] ms_cnt;
    logic        us;
    logic        ms;
  } tick_state_t;

  tick_state_t s_q;
  tick_state_t s_d;

  always_comb begin
    s_d        = s_q;
    s_d.us     = (s_q.us_cnt == US_LAST);
    s_d.ms     = (s_q.ms_cnt == MS_LAST);
    s_d.us_cnt = s_d.us ? 7'h00 : s_q.us_cnt + 7'h01;
    s_d.ms_cnt = s_d.ms ? 17'h00000 : s_q.ms_cnt + 17'h00001;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign ticks.tick_us = s_q.us;
  assign ticks.tick_ms = s_q.ms;
endmodule : tick_gen
`default_nettype wire

//--- core/charge_cycle_sequencer.sv
// Charge cycle sequencer: phases, safety timers, faults and registers.
// Assumes comparator levels arrive asynchronously and rst_i is supply POR.
`timescale 1ns/1ps
`default_nettype none
module charge_cycle_sequencer import chg_pkg::*; #(
  parameter int unsigned       CYC_PER_MS = CYC_PER_MS_D,
  parameter logic [TMR_W-1:0]  LONG_MS    = TMR_W'(LONG_MS_D),
  parameter logic [TMR_W-1:0]  SHORT_MS   = TMR_W'(SHORT_MS_D)
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Analog comparator and strap inputs
  input  wire logic        batt_below_short_i,
  input  wire logic        batt_below_weak_i,
  input  wire logic        batt_above_recharge_i,
  input  wire logic        term_current_det_i,
  input  wire logic        thermal_shutdown_i,
  input  wire logic        poor_source_i,
  input  wire logic        input_ov_i,
  input  wire logic        battery_ov_i,
  input  wire logic        otg_pin_i,
  input  wire logic        auto_variant_i,
  // Power stage controls
  output logic             converter_on_o,
  output logic             precharge_o,
  output logic             detect_discharge_o,
  output logic             input_current_limit_500_o,
  output logic             input_current_limit_off_o,
  output logic      [3:0]  fast_current_o,
  output logic      [3:0]  termination_current_o,
  output logic      [5:0]  regulation_voltage_o,
  // Open-drain status pin
  output logic             stat_out_o,
  output logic             stat_oe_o
);
  localparam logic [TMR_W-1:0] LONG_LAST  = LONG_MS - TMR_W'(1);
  localparam logic [TMR_W-1:0] SHORT_LAST = SHORT_MS - TMR_W'(1);
  localparam logic [DLY_W-1:0] RETRY_LAST = DLY_W'(RETRY_MS - 1);
  localparam logic [DLY_W-1:0] DET_LAST   = DLY_W'(DETECT_MS - 1);
  localparam logic [7:0]       PULSE_LEN  = 8'(STAT_PULSE_US);
  localparam logic [1:0]       BOOT_LAST  = 2'h3;

  typedef enum logic [2:0] {
    ST_BOOT,
    ST_IDLE,
    ST_CHARGE,
    ST_DETECT,
    ST_RETRY,
    ST_DONE,
    ST_FAULT
  } phase_t;

  typedef struct packed {
    phase_t           phase;
    logic [1:0]       boot_cnt;
    logic [7:0]       ctrl;
    logic [13:0]      param;
    logic [2:0]       fault;
    logic             unread;
    logic             short_mode;
    logic [TMR_W-1:0] safety;
    logic [DLY_W-1:0] delay;
    logic [7:0]       pulse;
    logic [NPINS-1:0] prev;
    logic             ack;
    logic [31:0]      rdata;
    logic             conv;
    logic             pre;
    logic             dis;
    logic             stat_oe;
  } seq_state_t;

  seq_state_t s_q;
  seq_state_t n;

  tick_if ticks ();
  pin_if  pins ();

  pin_sync u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .raw_i ({auto_variant_i, otg_pin_i, battery_ov_i, input_ov_i,
             poor_source_i, thermal_shutdown_i, term_current_det_i,
             batt_above_recharge_i, batt_below_weak_i,
             batt_below_short_i}),
    .pins  (pins)
  );

  tick_gen #(
    .CYC_PER_MS (CYC_PER_MS)
  ) u_tick (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ticks (ticks)
  );

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  logic [NPINS-1:0] lv;
  logic             req;
  logic             wr;
  logic [31:0]      wmask;
  logic [31:0]      cur;
  logic [31:0]      upd;
  logic [2:0]       new_flt;
  logic             blocked;
  logic             run;
  logic             restart;
  logic             defaults;

  always_comb begin
    n        = s_q;
    lv       = pins.level;
    req      = wb_cyc_i & wb_stb_i & ~s_q.ack;
    wr       = req & wb_we_i;
    wmask    = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    cur      = 32'h0000_0000;
    upd      = 32'h0000_0000;
    new_flt  = FLT_NONE;
    restart  = 1'b0;
    defaults = 1'b0;
    n.ack    = req;
    n.prev   = lv;
    // Converter held off by any of these levels, timers frozen on heat.
    blocked  = lv[PIN_THERM] | lv[PIN_INOV] | lv[PIN_BATOV];
    run      = ticks.tick_ms & ~lv[PIN_THERM];

    // Self-clearing bits live for one cycle after the write.
    n.ctrl[CTL_PRST] = 1'b0;
    n.ctrl[CTL_KICK] = 1'b0;

    if (lv[PIN_INOV] & ~s_q.prev[PIN_INOV]) begin
      new_flt = FLT_INOV;
    end
    if (lv[PIN_BATOV] & ~s_q.prev[PIN_BATOV]) begin
      new_flt = FLT_BATOV;
    end
    if (lv[PIN_THERM] & ~s_q.prev[PIN_THERM]) begin
      new_flt = FLT_THERM;
    end

    case (s_q.phase)
      ST_BOOT: begin
        n.boot_cnt = s_q.boot_cnt + 2'h1;
        if (s_q.boot_cnt == BOOT_LAST) begin
          if (lv[PIN_WEAK] & lv[PIN_AUTO]) begin
            n.ctrl[CTL_IIN500] = lv[PIN_OTG];
            restart = 1'b1;
          end else if (lv[PIN_WEAK]) begin
            n.ctrl[CTL_HZ] = 1'b1;
            n.phase = ST_IDLE;
          end else begin
            n.phase = ST_IDLE;
          end
        end
      end
      ST_IDLE: begin
        if (!s_q.ctrl[CTL_DIS] && !s_q.ctrl[CTL_HZ]) begin
          restart = 1'b1;
        end
      end
      ST_CHARGE: begin
        if (lv[PIN_POOR]) begin
          new_flt = FLT_POOR;
          n.phase = ST_RETRY;
          n.delay = '0;
        end else if (!blocked && !lv[PIN_SHORT] && lv[PIN_TERM] &&
                     lv[PIN_RECH] && s_q.ctrl[CTL_TERM_EN]) begin
          n.phase = s_q.short_mode ? ST_DETECT : ST_DONE;
          n.delay = '0;
        end
      end
      ST_DETECT: begin
        if (run) begin
          n.delay = s_q.delay + DLY_W'(1);
          if (s_q.delay == DET_LAST) begin
            n.delay = '0;
            if (lv[PIN_RECH]) begin
              n.phase = ST_DONE;
            end else begin
              new_flt  = FLT_NOBAT;
              defaults = 1'b1;
              n.phase  = ST_RETRY;
            end
          end
        end
      end
      ST_RETRY: begin
        if (run) begin
          n.delay = s_q.delay + DLY_W'(1);
          if (s_q.delay == RETRY_LAST) begin
            restart = 1'b1;
          end
        end
      end
      ST_DONE: begin
        if (!lv[PIN_RECH]) begin
          restart = 1'b1;
        end
      end
      ST_FAULT: begin
        n.phase = ST_FAULT;
      end
      default: begin
        n.phase = ST_BOOT;
      end
    endcase

    // Safety timers count while a charge cycle is under way.
    if (s_q.phase == ST_CHARGE || s_q.phase == ST_DETECT ||
        s_q.phase == ST_RETRY) begin
      if (s_q.ctrl[CTL_KICK] && s_q.short_mode) begin
        n.safety = '0;
      end else if (run) begin
        n.safety = s_q.safety + TMR_W'(1);
        if (!s_q.short_mode && s_q.safety == LONG_LAST) begin
          n.phase = ST_FAULT;
          new_flt = FLT_TIMER;
          restart = 1'b0;
        end else if (s_q.short_mode && s_q.safety == SHORT_LAST) begin
          defaults = 1'b1;
          restart  = 1'b1;
        end
      end
    end

    // Disable or high impedance ends any cycle; re-enable starts a new one.
    if (s_q.phase != ST_BOOT && s_q.phase != ST_FAULT) begin
      if (s_q.ctrl[CTL_PRST]) begin
        defaults = 1'b1;
        restart  = 1'b1;
      end
      if (s_q.ctrl[CTL_DIS] || s_q.ctrl[CTL_HZ]) begin
        restart = 1'b0;
        n.phase = ST_IDLE;
      end
    end

    if (restart) begin
      n.phase      = ST_CHARGE;
      n.short_mode = 1'b0;
      n.safety     = '0;
      n.delay      = '0;
    end
    if (defaults) begin
      n.param               = PARAM_RESET;
      n.ctrl[CTL_TERM_EN]   = 1'b0;
      n.ctrl[CTL_IIN500]    = 1'b0;
      n.ctrl[CTL_IIN_OFF]   = 1'b0;
    end

    // --------------------------------------------------------------------
    // Register bus
    // --------------------------------------------------------------------
    case ({wb_adr_i[7:2], 2'b00})
      ADR_CTRL:   cur = {24'h000000, s_q.ctrl};
      ADR_PARAM:  cur = {18'h00000, s_q.param};
      ADR_STATUS: cur = {24'h000000, s_q.short_mode, s_q.phase,
                         1'b0, s_q.fault};
      default:    cur = 32'h0000_0000;
    endcase
    upd = (cur & ~wmask) | (wb_dat_i & wmask);
    if (req) begin
      n.rdata = cur;
    end
    if (wr) begin
      if ({wb_adr_i[7:2], 2'b00} == ADR_CTRL) begin
        n.ctrl = upd[7:0];
      end
      if ({wb_adr_i[7:2], 2'b00} == ADR_PARAM) begin
        n.param = upd[13:0];
      end
      if (!s_q.short_mode) begin
        n.short_mode = 1'b1;
        n.safety     = '0;
      end
    end
    if (req && !wb_we_i && {wb_adr_i[7:2], 2'b00} == ADR_STATUS) begin
      n.unread = 1'b0;
    end

    // Fault field locks until read; a new fault wins over the read.
    if (new_flt != FLT_NONE) begin
      n.pulse = PULSE_LEN;
      if (!n.unread) begin
        n.fault  = new_flt;
        n.unread = 1'b1;
      end
    end else if (ticks.tick_us && s_q.pulse != 8'h00) begin
      n.pulse = s_q.pulse - 8'h01;
    end
    if (!n.unread && n.fault != FLT_TIMER && n.fault != FLT_NONE &&
        !blocked) begin
      n.fault = FLT_NONE;
    end

    // Registered power stage and pin controls.
    n.conv    = (n.phase == ST_CHARGE) && !blocked;
    n.pre     = n.conv && lv[PIN_SHORT];
    n.dis     = (n.phase == ST_DETECT);
    n.stat_oe = (n.pulse != 8'h00) ||
                (n.conv && n.ctrl[CTL_STAT_EN]);
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q       <= '0;
      s_q.phase <= ST_BOOT;
      s_q.ctrl  <= CTRL_RESET;
      s_q.param <= PARAM_RESET;
      s_q.fault <= FLT_NONE;
    end else begin
      s_q <= n;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign wb_dat_o              = s_q.rdata;
  assign wb_ack_o              = s_q.ack;
  assign converter_on_o        = s_q.conv;
  assign precharge_o           = s_q.pre;
  assign detect_discharge_o    = s_q.dis;
  assign input_current_limit_500_o       = s_q.ctrl[CTL_IIN500];
  assign input_current_limit_off_o       = s_q.ctrl[CTL_IIN_OFF];
  assign fast_current_o        = s_q.param[FAST_LSB +: 4];
  assign termination_current_o = s_q.param[TERM_LSB +: 4];
  assign regulation_voltage_o  = s_q.param[VREG_LSB +: 6];
  assign stat_out_o            = 1'b0;
  assign stat_oe_o             = s_q.stat_oe;
endmodule : charge_cycle_sequencer
`default_nettype wire

//--- bench/charge_props.sv
// Concurrent checks on the top-level ports of the charge sequencer.
// Assumes comparator inputs pass a two-flop synchroniser before use.
`timescale 1ns/1ps
`default_nettype none
module charge_props (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Register bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  // Comparators and power stage
  input wire logic        batt_below_short_i,
  input wire logic        thermal_shutdown_i,
  input wire logic        input_ov_i,
  input wire logic        battery_ov_i,
  input wire logic        converter_on_o,
  input wire logic        precharge_o,
  input wire logic        detect_discharge_o,
  input wire logic        input_current_limit_500_o,
  input wire logic [5:0]  regulation_voltage_o,
  input wire logic        stat_out_o,
  input wire logic        stat_oe_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence held5(s); s[*5]; endsequence
  sequence bus_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence ctrl_off;
    wb_ack_o && wb_we_i && wb_adr_i[7:2] == 6'h00 && wb_sel_i[0] &&
    wb_dat_i[0];
  endsequence
  ack_req_a: assert property (bus_req |=> wb_ack_o)
    else $error("bus request not acknowledged");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  reset_state_a: assert property ($fell(rst_i) |-> !converter_on_o &&
    !input_current_limit_500_o && regulation_voltage_o == 6'h02)
    else $error("wrong output state after reset");
  therm_off_a: assert property (held5(thermal_shutdown_i) |->
    !converter_on_o) else $error("converter on in thermal shutdown");
  stat_pulse_a: assert property ($rose(thermal_shutdown_i) ##1
    thermal_shutdown_i[*4] |-> stat_oe_o && !stat_out_o)
    else $error("no status pulse on a fault");
  inov_off_a: assert property (held5(input_ov_i) |->
    !converter_on_o) else $error("converter on in input overvoltage");
  batov_off_a: assert property (held5(battery_ov_i) |->
    !converter_on_o) else $error("converter on in battery overvoltage");
  pre_on_a: assert property (held5(batt_below_short_i) ##0
    converter_on_o[*2] |-> precharge_o)
    else $error("full current into a shorted battery");
  pre_off_a: assert property (held5(!batt_below_short_i) |->
    !precharge_o) else $error("precharge above short threshold");
  dis_off_a: assert property (ctrl_off |-> ##[1:3] !converter_on_o)
    else $error("charge disable bit ignored");
  det_excl_a: assert property (detect_discharge_o |->
    !converter_on_o) else $error("detect current while charging");
endmodule : charge_props
bind charge_cycle_sequencer charge_props props (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
  .wb_dat_i, .wb_ack_o, .batt_below_short_i, .thermal_shutdown_i,
  .input_ov_i, .battery_ov_i, .converter_on_o, .precharge_o,
  .detect_discharge_o, .input_current_limit_500_o, .regulation_voltage_o,
  .stat_out_o, .stat_oe_o);
`default_nettype wire

//--- bench/host_model.sv
// Host processor model: a classic Wishbone master for register access.
// Assumes each transfer is entered just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // Clock and answer
  input  wire logic       clk_i,
  input  wire logic       ack_i,
  // Request
  output var logic        cyc_o = 1'b0,
  output var logic        stb_o = 1'b0,
  output var logic        we_o  = 1'b0,
  output var logic [7:0]  adr_o = 8'h00,
  output var logic [3:0]  sel_o = 4'h0,
  output var logic [31:0] dat_o = 32'h0
);
  // A random idle gap lets the host act promptly or slowly.
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    repeat ($urandom_range(2, 0)) @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= w;
    adr_o <= a;
    sel_o <= 4'hF;
    dat_o <= d;
    @(posedge clk_i);
    while (ack_i !== 1'b1) @(posedge clk_i);
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    dat_o <= ~d;
    @(posedge clk_i);
  endtask : xfer
endmodule : host_model
`default_nettype wire

//--- bench/charge_cycle_sequencer_tb_top.sv
// Self-checking bench for the charge cycle sequencer.
// Assumes the host model and the bound checker are compiled with it.
`timescale 1ns/1ps
`default_nettype none
module charge_cycle_sequencer_tb_top import chg_pkg::*;;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i, fast_current_o, termination_current_o;
  logic [31:0] wb_dat_i, wb_dat_o, rv;
  logic        batt_below_short_i, batt_below_weak_i, batt_above_recharge_i;
  logic        term_current_det_i, thermal_shutdown_i, poor_source_i;
  logic        input_ov_i, battery_ov_i, otg_pin_i, auto_variant_i;
  logic        converter_on_o, precharge_o, detect_discharge_o, stat_out_o;
  logic        input_current_limit_500_o, input_current_limit_off_o, stat_oe_o;
  logic [5:0]  regulation_voltage_o;
  int          err_count = 0;
  int          samples_checked = 0;
  logic [31:0] expq[$];
  charge_cycle_sequencer #(.CYC_PER_MS(200), .LONG_MS(21'h28),
    .SHORT_MS(21'h0A)) dut (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .batt_below_short_i,
    .batt_below_weak_i, .batt_above_recharge_i, .term_current_det_i,
    .thermal_shutdown_i, .poor_source_i, .input_ov_i, .battery_ov_i,
    .otg_pin_i, .auto_variant_i, .converter_on_o, .precharge_o,
    .detect_discharge_o, .input_current_limit_500_o, .input_current_limit_off_o,
    .fast_current_o, .termination_current_o, .regulation_voltage_o,
    .stat_out_o, .stat_oe_o);
  host_model host (.clk_i, .ack_i(wb_ack_o), .cyc_o(wb_cyc_i),
    .stb_o(wb_stb_i), .we_o(wb_we_i), .adr_o(wb_adr_i), .sel_o(wb_sel_i),
    .dat_o(wb_dat_i));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_of_test();
    $display("checks %0d, errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  task automatic waitc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : waitc
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expq.push_back(e);
    host.xfer(1'b0, a, 32'h0);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d);
  endtask : wr
  task automatic boot(input logic w, input logic a, input logic o);
    rst_i <= 1'b1;
    {batt_below_weak_i, auto_variant_i, otg_pin_i} <= {w, a, o};
    waitc(2);
    rst_i <= 1'b0;
    waitc(12);
  endtask : boot
  // Read data is compared against the oldest expectation at each read ack.
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_cyc_i && !wb_we_i) begin
      chk(wb_dat_o, expq.pop_front());
    end
  end
  initial begin
    waitc(60000);
    err_count++;
    end_of_test();
  end
  initial begin
    {batt_below_short_i, batt_below_weak_i, batt_above_recharge_i,
     term_current_det_i, thermal_shutdown_i, poor_source_i, input_ov_i,
     battery_ov_i, otg_pin_i, auto_variant_i} = '0;
    rst_i = 1'b1;
    rv = $urandom(32'h2EBB);
    boot(1'b0, 1'b1, 1'b0);
    rd(ADR_CTRL, 32'h0);
    rd(ADR_PARAM, {18'h00000, PARAM_RESET});
    chk(termination_current_o, 32'(TERM_RESET));
    chk(stat_out_o, 32'h0);
    chk(converter_on_o, 32'h1);
    chk(input_current_limit_500_o, 32'h0);
    chk(regulation_voltage_o, 32'h2);
    batt_below_short_i <= 1'b1;
    waitc(6);
    chk(precharge_o, 32'h1);
    batt_below_short_i <= 1'b0;
    thermal_shutdown_i <= 1'b1;
    waitc(6);
    chk(converter_on_o, 32'h0);
    chk(stat_oe_o, 32'h1);
    waitc(12850);
    chk(stat_oe_o, 32'h0);
    thermal_shutdown_i <= 1'b0;
    waitc(6);
    chk(converter_on_o, 32'h1);
    rd(ADR_STATUS, 32'h23);
    rd(ADR_STATUS, 32'h20);
    waitc(8400);
    rd(ADR_STATUS, 32'h64);
    chk(converter_on_o, 32'h0);
    boot(1'b0, 1'b1, 1'b0);
    wr(8'h3C, 32'hFFFF);
    rd(ADR_STATUS, 32'hA0);
    rd(8'h3C, 32'h0);
    rv = {18'h0, rv[13:0] ^ 14'($urandom())};
    wr(ADR_PARAM, rv);
    rd(ADR_PARAM, rv);
    chk(fast_current_o, rv[3:0]);
    waitc(1500);
    wr(ADR_CTRL, 32'h90);
    rd(ADR_CTRL, 32'h80);
    chk(input_current_limit_off_o, 32'h1);
    waitc(1500);
    rd(ADR_PARAM, rv);
    waitc(600);
    rd(ADR_PARAM, {18'h00000, PARAM_RESET});
    rd(ADR_STATUS, 32'h20);
    chk(input_current_limit_off_o, 32'h0);
    wr(ADR_CTRL, 32'h01);
    waitc(4);
    chk(converter_on_o, 32'h0);
    wr(ADR_CTRL, 32'h00);
    waitc(4);
    chk(converter_on_o, 32'h1);
    wr(ADR_PARAM, rv);
    wr(ADR_CTRL, 32'h08);
    rd(ADR_PARAM, {18'h00000, PARAM_RESET});
    rd(ADR_CTRL, 32'h0);
    {batt_above_recharge_i, term_current_det_i} <= 2'h3;
    waitc(6);
    chk(converter_on_o, 32'h1);
    wr(ADR_CTRL, 32'h02);
    waitc(6);
    chk(detect_discharge_o, 32'h1);
    chk(converter_on_o, 32'h0);
    {batt_above_recharge_i, term_current_det_i} <= 2'h0;
    boot(1'b0, 1'b1, 1'b0);
    {input_ov_i, battery_ov_i} <= 2'h2;
    waitc(6);
    chk(converter_on_o, 32'h0);
    {input_ov_i, battery_ov_i} <= 2'h1;
    waitc(6);
    chk(converter_on_o, 32'h0);
    battery_ov_i <= 1'b0;
    waitc(6);
    chk(converter_on_o, 32'h1);
    {input_ov_i, battery_ov_i, poor_source_i} <= 3'h1;
    waitc(6);
    chk(converter_on_o, 32'h0);
    poor_source_i <= 1'b0;
    boot(1'b1, 1'b1, 1'b1);
    rd(ADR_CTRL, 32'h40);
    chk(input_current_limit_500_o, 32'h1);
    wr(ADR_CTRL, 32'h44);
    waitc(4);
    chk(stat_oe_o, 32'h1);
    boot(1'b1, 1'b0, 1'b0);
    rd(ADR_CTRL, 32'h20);
    chk(converter_on_o, 32'h0);
    end_of_test();
  end
endmodule : charge_cycle_sequencer_tb_top
`default_nettype wire
